// >>> rtl/exc_pkg.sv
// Shared constants and carrier types for the software exception unit.
// Assumes a 32-bit core whose decoder flags trap and return instructions for one cycle.
package exc_pkg;

	// Width of the trap operand vector.
	localparam int unsigned VEC_W = 5;

	// Width of the cause code field in the low half of the cause register.
	localparam int unsigned CAUSE_CODE_W = 16;

	// Handler entry addresses for the two vector ranges.
	localparam logic [31:0] HANDLER_LOW_ADDR  = 32'h00000040;
	localparam logic [31:0] HANDLER_HIGH_ADDR = 32'h00000050;

	// First vector that selects the high handler.
	localparam logic [4:0] VEC_HIGH_FIRST = 5'h10;

	// Base of the cause code written on trap entry; the vector is added to it.
	localparam logic [15:0] TRAP_CODE_BASE = 16'h0040;

	// Status word field positions.
	localparam int unsigned PSW_ID_BIT = 5;
	localparam int unsigned PSW_EXC_BIT = 6;

	// Status word bits that exist; the rest read as zero.
	localparam logic [31:0] PSW_WMASK = 32'h000000ff;

	// Values after reset.
	localparam logic [31:0] PSW_RESET   = 32'h00000020;
	localparam logic [31:0] SAVE_RESET  = 32'h00000000;
	localparam logic [31:0] CAUSE_RESET = 32'h00000000;

	// Register byte offsets on the bus.
	localparam logic [7:0] REG_PSW_OFS    = 8'h00;
	localparam logic [7:0] REG_SAVED_PC_OFS  = 8'h04;
	localparam logic [7:0] REG_SAVED_PSW_OFS = 8'h08;
	localparam logic [7:0] REG_CAUSE_OFS  = 8'h0c;
	localparam logic [7:0] REG_STATUS_OFS = 8'h10;

	// Status register bit positions.
	localparam int unsigned STAT_EXC_BIT     = 0;
	localparam int unsigned STAT_REFUSED_BIT = 1;

	// Bus response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// One-cycle request from the decoder.
	typedef struct packed {
		logic             trap;
		logic             exc_return;
		logic [VEC_W-1:0] vector;
		logic [31:0]      return_pc;
	} exc_cmd_s;

endpackage

// >>> rtl/handler_select.sv
// Maps a trap operand vector to its handler address and cause code.
// Pure combinational; the caller registers the results.
`timescale 1ns/1ps
module handler_select #(
	parameter int unsigned VW = 5
) (
	input  wire logic [VW-1:0] vector,
	input  wire logic [15:0]   code_base,
	output logic      [31:0]   handler_addr,
	output logic      [15:0]   cause_code
);
	import exc_pkg::*;

	// The range split sits at bit 4, so narrower vectors cannot reach the high handler.
	if (VW != VEC_W) begin : g_width_check
		$error("handler_select: vector width must equal VEC_W");
	end

	// Vectors 0 to 0fh go low, 10h to 1fh go high.
	always_comb begin
		if (vector >= VEC_HIGH_FIRST) begin
			handler_addr = HANDLER_HIGH_ADDR;
		end else begin
			handler_addr = HANDLER_LOW_ADDR;
		end
		cause_code = code_base + {11'h000, vector};
	end

endmodule

// >>> rtl/exc_unit.sv
// Software exception entry and return unit with an AXI4-Lite register window.
// Assumes the decoder pulses trap or return for one cycle and that the fetch unit
// takes pc_load_q with pc_target_q and starts the handler in the cycle after.
// Summary of operation
// - Trap instruction always accepted, ignoring interrupt disable.
// - Entry saves return PC into save register.
// - Entry saves status word before changing flags.
// - Entry writes source code into low cause field.
// - Entry sets exception and interrupt disable flags.
// - Vector 0 to 0fh jumps to 40h.
// - Vector 10h to 1fh jumps to 50h.
// - Return with flag set restores PC and status.
// - Execution resumes at restored PC, restored status.
// - Exception flag is status bit six.
`timescale 1ns/1ps
module exc_unit #(
	parameter logic [15:0] CODE_BASE = exc_pkg::TRAP_CODE_BASE
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire exc_pkg::exc_cmd_s cmd,
	output logic                  pc_load_q,
	output logic [31:0]           pc_target_q,
	output logic [31:0]           psw_q,
	input  wire logic [7:0]       s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	input  wire logic [7:0]       s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready
);
	import exc_pkg::*;

	logic [31:0] saved_pc_q;    // Saved return PC.
	logic [31:0] saved_psw_q;   // Saved status word.
	logic [31:0] cause_q;       // Cause register, code in the low half.
	logic        refused_q;     // Sticky: a return arrived with no exception in progress.
	logic [31:0] handler_addr;  // Handler for the current vector.
	logic [15:0] cause_code;    // Code for the current vector.
	logic        do_trap;       // Trap entry this cycle.
	logic        do_return;     // Accepted return this cycle.
	logic        bad_return;    // Return that finds no exception in progress.
	logic        hw_event;      // Any hardware update of the state this cycle.
	logic [7:0]  aw_addr_q;     // Held write address.
	logic        aw_held_q;     // Write address captured.
	logic [31:0] w_data_q;      // Held write data.
	logic [3:0]  w_strb_q;      // Held byte strobes.
	logic        w_held_q;      // Write data captured.
	logic        wr_fire;       // Register write performed this cycle.
	logic [31:0] wr_mask;       // Byte-lane mask from the strobes.
	logic [31:0] rd_word;       // Read mux output.
	logic        rd_hit;        // Read address is mapped.
	logic        wr_hit;        // Write address is mapped and writable.

	handler_select #(
		.VW(VEC_W)
	) u_sel (
		.vector       (cmd.vector),
		.code_base    (CODE_BASE),
		.handler_addr (handler_addr),
		.cause_code   (cause_code)
	);

	// A trap wins over a return in the same cycle, since the return can be retried
	// by software but a lost trap would skip a system call.
	always_comb begin
		do_trap  = cmd.trap;
		do_return  = cmd.exc_return && !cmd.trap && psw_q[PSW_EXC_BIT];
		bad_return = cmd.exc_return && !cmd.trap && !psw_q[PSW_EXC_BIT];
		hw_event   = cmd.trap || cmd.exc_return;
	end

	// Bus writes wait for a cycle with no hardware update, so neither side is lost.
	always_comb begin
		wr_fire = aw_held_q && w_held_q && !s_axi_bvalid && !hw_event;
		wr_mask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
		wr_hit  = (aw_addr_q == REG_PSW_OFS) || (aw_addr_q == REG_SAVED_PC_OFS) ||
			(aw_addr_q == REG_SAVED_PSW_OFS) || (aw_addr_q == REG_STATUS_OFS);
	end

	// Status word: entry sets the flags, return restores it, software may write it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			psw_q <= PSW_RESET;
		end else if (do_trap) begin
			// Flags are set on the old word, which was copied to the save register.
			psw_q[PSW_EXC_BIT] <= 1'b1;
			psw_q[PSW_ID_BIT]  <= 1'b1;
		end else if (do_return) begin
			psw_q <= saved_psw_q & PSW_WMASK;
		end else if (wr_fire && aw_addr_q == REG_PSW_OFS) begin
			psw_q <= ((psw_q & ~wr_mask) | (w_data_q & wr_mask)) & PSW_WMASK;
		end
	end

	// Save registers are written by entry and by software for nested handlers.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			saved_pc_q  <= SAVE_RESET;
			saved_psw_q <= SAVE_RESET;
		end else if (do_trap) begin
			saved_pc_q  <= cmd.return_pc;
			saved_psw_q <= psw_q;
		end else if (wr_fire && aw_addr_q == REG_SAVED_PC_OFS) begin
			saved_pc_q <= (saved_pc_q & ~wr_mask) | (w_data_q & wr_mask);
		end else if (wr_fire && aw_addr_q == REG_SAVED_PSW_OFS) begin
			saved_psw_q <= ((saved_psw_q & ~wr_mask) | (w_data_q & wr_mask)) & PSW_WMASK;
		end
	end

	// Cause register is read-only to software; only trap entry changes it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cause_q <= CAUSE_RESET;
		end else if (do_trap) begin
			cause_q[CAUSE_CODE_W-1:0] <= cause_code;
		end
	end

	// Refused-return flag; a clearing write waits out a new refusal, then clears the flag.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			refused_q <= 1'b0;
		end else if (bad_return) begin
			refused_q <= 1'b1;
		end else if (wr_fire && aw_addr_q == REG_STATUS_OFS && w_strb_q[0] &&
			w_data_q[STAT_REFUSED_BIT]) begin
			refused_q <= 1'b0;
		end
	end

	// Program counter redirect, registered so the whole entry is visible together.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc_load_q   <= 1'b0;
			pc_target_q <= HANDLER_LOW_ADDR;
		end else begin
			pc_load_q <= do_trap || do_return;
			if (do_trap) begin
				pc_target_q <= handler_addr;
			end else if (do_return) begin
				pc_target_q <= saved_pc_q;
			end
		end
	end

	// Write address and data channels are captured independently, in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_q <= 1'b1;
			aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
		end else if (wr_fire) begin
			aw_held_q <= 1'b0;
		end
	end

	// Write data holding register.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_q <= 1'b0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held_q <= 1'b0;
		end
	end

	// Ready is dropped while a channel holds an item, which back-pressures the master.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= !(aw_held_q || (s_axi_awvalid && s_axi_awready)) || wr_fire;
			s_axi_wready  <= !(w_held_q || (s_axi_wvalid && s_axi_wready)) || wr_fire;
		end
	end

	// Write response; unmapped or read-only addresses answer with a slave error.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read mux; unmapped offsets read zero.
	always_comb begin
		rd_hit  = 1'b1;
		rd_word = 32'h00000000;
		case ({s_axi_araddr[7:2], 2'b00})
			REG_PSW_OFS: begin
				rd_word = psw_q;
			end
			REG_SAVED_PC_OFS: begin
				rd_word = saved_pc_q;
			end
			REG_SAVED_PSW_OFS: begin
				rd_word = saved_psw_q;
			end
			REG_CAUSE_OFS: begin
				rd_word = cause_q;
			end
			REG_STATUS_OFS: begin
				rd_word[STAT_EXC_BIT]     = psw_q[PSW_EXC_BIT];
				rd_word[STAT_REFUSED_BIT] = refused_q;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// Read channel: one read at a time, answered the cycle after the address.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	// Checks on the entry and return sequences.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_TRAP_ACCEPTED: assert property (
		cmd.trap && psw_q[PSW_ID_BIT] |=> pc_load_q && pc_target_q[31:7] == 25'h0000000)
		else $error("Trap with interrupts disabled was not taken.");

	AST_PC_SAVE: assert property (
		cmd.trap |=> saved_pc_q == $past(cmd.return_pc))
		else $error("Return PC not saved on trap entry.");

	AST_PSW_SAVE: assert property (
		cmd.trap |=> saved_psw_q == $past(psw_q))
		else $error("Old status word not saved on trap entry.");

	AST_CAUSE_CODE: assert property (
		cmd.trap |=> cause_q[15:0] == CODE_BASE + {11'h000, $past(cmd.vector)})
		else $error("Wrong cause code after trap entry.");

	AST_FLAGS_SET: assert property (
		cmd.trap |=> psw_q[6] && psw_q[PSW_ID_BIT])
		else $error("Exception or disable flag not set after entry.");

	AST_VEC_LOW: assert property (
		cmd.trap && cmd.vector < VEC_HIGH_FIRST |=> pc_target_q == HANDLER_LOW_ADDR)
		else $error("Low vector did not select the low handler.");

	AST_VEC_HIGH: assert property (
		cmd.trap && cmd.vector >= VEC_HIGH_FIRST |=> pc_target_q == HANDLER_HIGH_ADDR)
		else $error("High vector did not select the high handler.");

	AST_RETURN_RESTORE: assert property (
		cmd.exc_return && !cmd.trap && psw_q[PSW_EXC_BIT] |=>
		pc_load_q && pc_target_q == $past(saved_pc_q) &&
		psw_q == ($past(saved_psw_q) & PSW_WMASK))
		else $error("Return did not restore PC and status word.");

	AST_RETURN_REFUSED: assert property (
		cmd.exc_return && !cmd.trap && !psw_q[PSW_EXC_BIT] |=> !pc_load_q && refused_q)
		else $error("Return without exception in progress was not refused.");

	AST_ENTRY_CONSISTENT: assert property (
		cmd.trap ##1 pc_load_q |-> psw_q[PSW_EXC_BIT] && saved_psw_q == $past(psw_q) &&
		saved_pc_q == $past(cmd.return_pc))
		else $error("Redirect visible before entry state settled.");

	COV_TRAP_LOW: cover property (cmd.trap && cmd.vector < VEC_HIGH_FIRST);
	COV_TRAP_HIGH: cover property (cmd.trap && cmd.vector >= VEC_HIGH_FIRST);
	COV_TRAP_THEN_RETURN: cover property (cmd.trap ##[1:20]
		(cmd.exc_return && psw_q[PSW_EXC_BIT]));
	COV_BUS_WRITE_STALLED: cover property (aw_held_q && w_held_q && hw_event);

endmodule

// >>> sim/dec_model.sv
// Model of the decoder and program counter that face the exception unit.
// Assumes the bench calls issue() from one thread, one event at a time.
`timescale 1ns/1ps
module dec_model (
	input  wire logic          aclk,
	input  wire logic          pc_load_q,
	input  wire logic [31:0]   pc_target_q,
	output exc_pkg::exc_cmd_s  cmd,
	output logic [31:0]        pc_q
);
	import exc_pkg::*;

	// Start idle so nothing is taken during reset.
	initial begin
		cmd = '0;
		pc_q = 32'h0;
	end

	// Fetch follows every redirect and continues at the new address.
	always @(posedge aclk) begin
		if (pc_load_q) begin
			pc_q <= pc_target_q;
		end
	end

	// One-cycle decoder pulse; operands are scrambled afterwards so a stale read shows up.
	task automatic issue(input logic t, input logic r, input logic [4:0] v, input logic [31:0] pc);
		@(posedge aclk);
		cmd <= '{trap: t, exc_return: r, vector: v, return_pc: pc};
		@(posedge aclk);
		cmd <= '{trap: 1'b0, exc_return: 1'b0, vector: ~v, return_pc: ~pc};
	endtask
endmodule

// >>> sim/test_exc_unit.sv
// Self-checking bench for the exception unit: decoder events and register reads.
// Assumes the decoder model in dec_model.sv and an AXI4-Lite master here.
`timescale 1ns/1ps
module test_exc_unit;
	import exc_pkg::*;

	logic              aclk;
	logic              aresetn;
	exc_cmd_s          cmd;
	logic              pc_load_q;
	logic [31:0]       pc_target_q;
	logic [31:0]       psw_q;
	logic [31:0]       pc_q;
	logic [7:0]        s_axi_awaddr;
	logic [7:0]        s_axi_araddr;
	logic [31:0]       s_axi_wdata;
	logic [31:0]       s_axi_rdata;
	logic [3:0]        s_axi_wstrb;
	logic [1:0]        s_axi_bresp;
	logic [1:0]        s_axi_rresp;
	logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic              s_axi_rvalid, s_axi_rready;
	int                fail_count;
	int                n_tests;
	int                k;

	exc_unit DUT (.aclk(aclk), .aresetn(aresetn), .cmd(cmd), .pc_load_q(pc_load_q),
		.pc_target_q(pc_target_q), .psw_q(psw_q), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));

	dec_model u_dec (.aclk(aclk), .pc_load_q(pc_load_q), .pc_target_q(pc_target_q),
		.cmd(cmd), .pc_q(pc_q));

	// Free-running 10 MHz clock.
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// Prints the counts and the verdict, then stops.
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Compares one value; four-state equality so an unknown only matches an identical unknown.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// A wait that ran out is a mismatch and ends the run.
	task automatic tmo(input int i);
		if (i >= 50) begin
			fail_count++;
			$display("ERROR %0t bus wait ran out", $time);
			close_out();
		end
	endtask

	// Write: address and data offered together, each dropped once taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int i;
		logic aw_d, w_d;
		aw_d = 1'b0;
		w_d = 1'b0;
		i = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_d && w_d) && i < 50) begin
			@(posedge aclk);
			i++;
			if (!aw_d && s_axi_awready) begin
				aw_d = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_d && s_axi_wready) begin
				w_d = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		tmo(i);
		i = 0;
		do begin
			@(posedge aclk);
			i++;
		end while (!s_axi_bvalid && i < 50);
		s_axi_bready <= 1'b0;
		tmo(i);
		chk({30'h0, s_axi_bresp}, {30'h0, er}, "bresp");
	endtask

	// Read: rready held until rvalid is sampled high.
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int i;
		i = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			i++;
		end while (!s_axi_arready && i < 50);
		s_axi_arvalid <= 1'b0;
		tmo(i);
		i = 0;
		do begin
			@(posedge aclk);
			i++;
		end while (!s_axi_rvalid && i < 50);
		s_axi_rready <= 1'b0;
		tmo(i);
		chk(s_axi_rdata, ed, "rdata");
		chk({30'h0, s_axi_rresp}, {30'h0, er}, "rresp");
	endtask

	// One decoder event, then the redirect pulse and status word are checked.
	task automatic ev(input logic t, input logic r, input logic [4:0] v, input logic [31:0] pc,
		input logic ld, input logic [31:0] tgt, input logic [31:0] program_status_word);
		u_dec.issue(t, r, v, pc);
		@(negedge aclk);
		chk({31'h0, pc_load_q}, {31'h0, ld}, "load");
		if (ld) begin
			chk(pc_target_q, tgt, "target");
		end
		chk(psw_q, program_status_word, "psw");
		@(negedge aclk);
		chk({31'h0, pc_load_q}, 32'h0, "load end");
	endtask

	// Main sequence; inputs change only by non-blocking assignment at rising edges.
	initial begin
		fail_count = 0;
		n_tests = 0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		s_axi_awaddr = 8'h0;
		s_axi_araddr = 8'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		for (k = 1; k < 5; k++) begin
			rd(8'(4 * k), 32'h0, RESP_OKAY);
		end
		rd(REG_PSW_OFS, PSW_RESET, RESP_OKAY);
		rd(8'h14, 32'h0, RESP_SLVERR);
		wr(REG_PSW_OFS, 32'h0000002f, RESP_OKAY);
		ev(1'b1, 1'b0, 5'h0f, 32'h00001234, 1'b1, HANDLER_LOW_ADDR, 32'h6f);
		rd(REG_SAVED_PC_OFS, 32'h00001234, RESP_OKAY);
		rd(REG_SAVED_PSW_OFS, 32'h0000002f, RESP_OKAY);
		rd(REG_CAUSE_OFS, 32'h0000004f, RESP_OKAY);
		rd(REG_STATUS_OFS, 32'h1, RESP_OKAY);
		ev(1'b0, 1'b1, 5'h0, 32'h0, 1'b1, 32'h00001234, 32'h2f);
		chk(pc_q, 32'h00001234, "resume pc");
		ev(1'b0, 1'b1, 5'h0, 32'h0, 1'b0, 32'h0, 32'h2f);
		rd(REG_STATUS_OFS, 32'h2, RESP_OKAY);
		wr(REG_STATUS_OFS, 32'h2, RESP_OKAY);
		rd(REG_STATUS_OFS, 32'h0, RESP_OKAY);
		ev(1'b1, 1'b0, 5'h10, 32'h000000a0, 1'b1, HANDLER_HIGH_ADDR, 32'h6f);
		ev(1'b1, 1'b0, 5'h1f, 32'h000000b0, 1'b1, HANDLER_HIGH_ADDR, 32'h6f);
		rd(REG_SAVED_PSW_OFS, 32'h0000006f, RESP_OKAY);
		rd(REG_SAVED_PC_OFS, 32'h000000b0, RESP_OKAY);
		wr(REG_CAUSE_OFS, 32'h0000ffff, RESP_SLVERR);
		rd(REG_CAUSE_OFS, 32'h0000005f, RESP_OKAY);
		ev(1'b0, 1'b1, 5'h0, 32'h0, 1'b1, 32'h000000b0, 32'h6f);
		wr(REG_PSW_OFS, 32'h00000001, RESP_OKAY);
		ev(1'b1, 1'b1, 5'h00, 32'h000000c0, 1'b1, HANDLER_LOW_ADDR, 32'h61);
		rd(REG_CAUSE_OFS, 32'h00000040, RESP_OKAY);
		// Only byte lane 1 of the saved PC may change under a partial strobe.
		s_axi_wstrb <= 4'h2;
		wr(REG_SAVED_PC_OFS, 32'hffffffff, RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		rd(REG_SAVED_PC_OFS, 32'h0000ffc0, RESP_OKAY);
		close_out();
	end
endmodule
